/* File: ele_pkg.sv */
// Package for the pin event unit: register map, field layout, reset values
// and the bus carrier types. Assumes a 32-bit APB with 12-bit offsets.
package ele_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int ELE_PIN_LINES = 16;
  localparam int ELE_LINES = 17;
  localparam int ELE_PINS = 18;
  localparam int ELE_SEL_W = 5;
  localparam int ELE_SEL_STRIDE = 8;
  localparam int ELE_SEL_PER_REG = 4;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] ELE_OFF_SRC0 = 12'h000;
  localparam logic [11:0] ELE_OFF_SRC1 = 12'h004;
  localparam logic [11:0] ELE_OFF_SRC2 = 12'h008;
  localparam logic [11:0] ELE_OFF_SRC3 = 12'h00c;
  localparam logic [11:0] ELE_OFF_RISE = 12'h010;
  localparam logic [11:0] ELE_OFF_FALL = 12'h014;
  localparam logic [11:0] ELE_OFF_INTEN = 12'h018;
  localparam logic [11:0] ELE_OFF_EVTEN = 12'h01c;
  localparam logic [11:0] ELE_OFF_PEND = 12'h020;
  localparam logic [11:0] ELE_OFF_CLR = 12'h024;
  localparam logic [11:0] ELE_OFF_STAT = 12'h028;

  // ------------------------------------------------------------------
  // Reset values and status fields
  // ------------------------------------------------------------------
  localparam logic [ELE_SEL_W-1:0] ELE_SEL_RST = 5'h00;
  localparam logic [ELE_LINES-1:0] ELE_LINE_RST = 17'h00000;
  localparam int ELE_STAT_STOP_BIT = 0;
  localparam int ELE_STAT_IRQ_BIT = 1;
  localparam int ELE_STAT_WAKE_BIT = 2;

  // ------------------------------------------------------------------
  // Bus carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ele_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ele_apb_rsp_t;

endpackage : ele_pkg

/* File: ele_edge_cell.sv */
// One edge catcher: narrow-pulse capture by toggles clocked from the input,
// brought into core_clk by two-flop synchronisers.
// Assumes sig_in is glitch free; every transition counts as an edge.
`timescale 1ns/1ps
module ele_edge_cell (
  input wire logic core_clk, // bus clock
  input wire logic reset_n, // async reset, active low
  input wire logic sig_in, // selected line source
  output logic rise_pulse, // one-cycle pulse per rising edge
  output logic fall_pulse, // one-cycle pulse per falling edge
  output logic rise_pending, // rising edge caught, not yet seen
  output logic fall_pending // falling edge caught, not yet seen
);
  import ele_pkg::*;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] seen;
    logic [1:0] pulse;
  } ele_cell_state_t;

  ele_cell_state_t s_q, s_d;
  logic rise_tog;
  logic fall_tog;

  // ------------------------------------------------------------------
  // Input-clocked toggles
  // ------------------------------------------------------------------
  // The line itself clocks these, so a pulse far shorter than one bus
  // period still flips a toggle and is never missed.
  always_ff @(posedge sig_in or negedge reset_n) begin
    if (!reset_n) begin
      rise_tog <= 1'b0;
    end else begin
      rise_tog <= ~rise_tog;
    end
  end

  always_ff @(negedge sig_in or negedge reset_n) begin
    if (!reset_n) begin
      fall_tog <= 1'b0;
    end else begin
      fall_tog <= ~fall_tog;
    end
  end

  // ------------------------------------------------------------------
  // Crossing into core_clk
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.sync1 = {fall_tog, rise_tog};
    s_d.sync2 = s_q.sync1;
    s_d.seen = s_q.sync2;
    s_d.pulse = s_q.sync2 ^ s_q.seen;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rise_pulse = s_q.pulse[0];
  assign fall_pulse = s_q.pulse[1];
  // Clockless path for wake-up while core_clk is stopped
  assign rise_pending = rise_tog ^ s_q.seen[0];
  assign fall_pending = fall_tog ^ s_q.seen[1];

endmodule : ele_edge_cell

/* File: ele_top.sv */
// Pin event unit: sixteen pin-routed lines plus the supply monitor line,
// edge triggers, masks, pending flags, one interrupt and event pulses.
// Assumes an APB master on core_clk and glitch-free pin inputs.
//
// Summary of operation
// - Any of the general I/O pins may be routed to each of sixteen lines.
// - Each line has an edge detector raising an interrupt or event request.
// - Each line triggers on rising, falling or both edges, set independently.
// - Each line has its own mask; a masked line forwards nothing.
// - A pending register holds one status bit per line.
// - Pulses narrower than one bus clock period are still captured.
// - Unit works in stop state; enabled triggers request wake-up.
// - Supply threshold monitor output is an extra request source line.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module ele_top (
  input wire logic core_clk, // bus clock, 50 MHz
  input wire logic reset_n, // async reset, active low
  input wire ele_pkg::ele_apb_req_t apb_req, // APB request
  output ele_pkg::ele_apb_rsp_t apb_rsp, // APB answer
  input wire logic [ele_pkg::ELE_PINS-1:0] gpio_in, // pin levels
  input wire logic supply_threshold_monitor, // supply monitor output
  input wire logic stop_mode, // device is in stop state
  output logic irq, // level interrupt to processor
  output logic [ele_pkg::ELE_LINES-1:0] event_pulse, // event requests
  output logic wake_req // wake-up request from stop
);
  import ele_pkg::*;

  typedef struct packed {
    logic [ELE_PIN_LINES-1:0][ELE_SEL_W-1:0] sel;
    logic [ELE_LINES-1:0] rise_en;
    logic [ELE_LINES-1:0] fall_en;
    logic [ELE_LINES-1:0] int_en;
    logic [ELE_LINES-1:0] evt_en;
    logic [ELE_LINES-1:0] pend;
    logic [ELE_LINES-1:0] evt;
    logic irq;
    logic [31:0] rdata;
    logic slverr;
  } ele_state_t;

  ele_state_t s_q, s_d;
  logic [ELE_LINES-1:0] line_src;
  logic [ELE_LINES-1:0] rise_p;
  logic [ELE_LINES-1:0] fall_p;
  logic [ELE_LINES-1:0] rise_h;
  logic [ELE_LINES-1:0] fall_h;
  logic [ELE_LINES-1:0] trig;
  logic [ELE_LINES-1:0] clr;
  logic [ELE_LINES-1:0] async_hit;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr == off);
  endfunction : hit

  // Out-of-range selects route no pin, so the line idles low
  function automatic logic pin_pick(input logic [ELE_PINS-1:0] pins,
                                    input logic [ELE_SEL_W-1:0] sel);
    logic r;
    r = 1'b0;
    for (int p = 0; p < ELE_PINS; p++) begin
      if (sel == p[ELE_SEL_W-1:0]) begin
        r = pins[p];
      end
    end
    pin_pick = r;
  endfunction : pin_pick

  function automatic logic mapped(input logic [11:0] addr);
    mapped = hit(addr, ELE_OFF_SRC0) | hit(addr, ELE_OFF_SRC1) |
             hit(addr, ELE_OFF_SRC2) | hit(addr, ELE_OFF_SRC3) |
             hit(addr, ELE_OFF_RISE) | hit(addr, ELE_OFF_FALL) |
             hit(addr, ELE_OFF_INTEN) | hit(addr, ELE_OFF_EVTEN) |
             hit(addr, ELE_OFF_PEND) | hit(addr, ELE_OFF_CLR) |
             hit(addr, ELE_OFF_STAT);
  endfunction : mapped

  // ------------------------------------------------------------------
  // Line sources and edge catchers
  // ------------------------------------------------------------------
  // Changing a select while pins differ may itself look like an edge;
  // software should clear pending after rerouting a line.
  genvar gi;
  generate
    for (gi = 0; gi < ELE_PIN_LINES; gi++) begin : g_src
      assign line_src[gi] = pin_pick(gpio_in, s_q.sel[gi]);
    end
  endgenerate
  assign line_src[ELE_PIN_LINES] = supply_threshold_monitor;

  generate
    for (gi = 0; gi < ELE_LINES; gi++) begin : g_cell
      ele_edge_cell u_cell (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .sig_in(line_src[gi]),
        .rise_pulse(rise_p[gi]),
        .fall_pulse(fall_p[gi]),
        .rise_pending(rise_h[gi]),
        .fall_pending(fall_h[gi])
      );
    end
  endgenerate

  // Two same-direction edges between two core_clk edges cancel out and give no pulse
  assign trig = (rise_p & s_q.rise_en) | (fall_p & s_q.fall_en);
  // Caught but not yet synchronised edges, used only while clocks may be off
  assign async_hit = ((rise_h & s_q.rise_en) | (fall_h & s_q.fall_en)) &
                     (s_q.int_en | s_q.evt_en);

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    logic wr;
    logic [31:0] rd;
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    rd = 32'h0000_0000;
    s_d = s_q;
    clr = '0;

    if (wr) begin
      for (int r = 0; r < ELE_SEL_PER_REG; r++) begin
        for (int f = 0; f < ELE_SEL_PER_REG; f++) begin
          if (hit(apb_req.paddr, ELE_OFF_SRC0 + 12'(4 * r))) begin
            s_d.sel[r * ELE_SEL_PER_REG + f] =
              apb_req.pwdata[f * ELE_SEL_STRIDE +: ELE_SEL_W];
          end
        end
      end
      if (hit(apb_req.paddr, ELE_OFF_RISE)) begin
        s_d.rise_en = apb_req.pwdata[ELE_LINES-1:0];
      end
      if (hit(apb_req.paddr, ELE_OFF_FALL)) begin
        s_d.fall_en = apb_req.pwdata[ELE_LINES-1:0];
      end
      if (hit(apb_req.paddr, ELE_OFF_INTEN)) begin
        s_d.int_en = apb_req.pwdata[ELE_LINES-1:0];
      end
      if (hit(apb_req.paddr, ELE_OFF_EVTEN)) begin
        s_d.evt_en = apb_req.pwdata[ELE_LINES-1:0];
      end
      if (hit(apb_req.paddr, ELE_OFF_PEND) | hit(apb_req.paddr, ELE_OFF_CLR)) begin
        clr = apb_req.pwdata[ELE_LINES-1:0];
      end
    end

    // A new edge in the clearing cycle wins over the clear
    s_d.pend = (s_q.pend & ~clr) | trig;
    s_d.evt = trig & s_q.evt_en;
    s_d.irq = |(s_d.pend & s_d.int_en);

    // Read data is captured in the setup cycle, answered in the access cycle
    if (apb_req.psel & ~apb_req.penable) begin
      for (int r = 0; r < ELE_SEL_PER_REG; r++) begin
        for (int f = 0; f < ELE_SEL_PER_REG; f++) begin
          if (hit(apb_req.paddr, ELE_OFF_SRC0 + 12'(4 * r))) begin
            rd[f * ELE_SEL_STRIDE +: ELE_SEL_W] = s_q.sel[r * ELE_SEL_PER_REG + f];
          end
        end
      end
      if (hit(apb_req.paddr, ELE_OFF_RISE)) begin
        rd[ELE_LINES-1:0] = s_q.rise_en;
      end
      if (hit(apb_req.paddr, ELE_OFF_FALL)) begin
        rd[ELE_LINES-1:0] = s_q.fall_en;
      end
      if (hit(apb_req.paddr, ELE_OFF_INTEN)) begin
        rd[ELE_LINES-1:0] = s_q.int_en;
      end
      if (hit(apb_req.paddr, ELE_OFF_EVTEN)) begin
        rd[ELE_LINES-1:0] = s_q.evt_en;
      end
      if (hit(apb_req.paddr, ELE_OFF_PEND)) begin
        rd[ELE_LINES-1:0] = s_q.pend;
      end
      // Status is a live view of the wake path; writes to it are ignored
      if (hit(apb_req.paddr, ELE_OFF_STAT)) begin
        rd[ELE_STAT_STOP_BIT] = stop_mode;
        rd[ELE_STAT_IRQ_BIT] = s_q.irq;
        rd[ELE_STAT_WAKE_BIT] = wake_req;
      end
      s_d.rdata = apb_req.pwrite ? 32'h0000_0000 : rd;
      s_d.slverr = ~mapped(apb_req.paddr);
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  // Reset is applied field by field so each field's reset value stays visible
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q.sel <= {ELE_PIN_LINES{ELE_SEL_RST}};
      s_q.rise_en <= ELE_LINE_RST;
      s_q.fall_en <= ELE_LINE_RST;
      s_q.int_en <= ELE_LINE_RST;
      s_q.evt_en <= ELE_LINE_RST;
      s_q.pend <= ELE_LINE_RST;
      s_q.evt <= ELE_LINE_RST;
      s_q.irq <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
      s_q.slverr <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign apb_rsp.prdata = s_q.rdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = s_q.slverr & apb_req.psel & apb_req.penable;
  assign irq = s_q.irq;
  assign event_pulse = s_q.evt;
  // The catch path needs no core_clk, so stop with clocks off still wakes
  assign wake_req = stop_mode & ((|async_hit) | s_q.irq);

endmodule : ele_top

/* File: ele_chk.sv */
// Port checker for the pin event unit.
// Assumes one clock domain; bound to ele_top from the bench.
`timescale 1ns/1ps
module ele_chk
  import ele_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic reset_n, // reset
  input wire ele_pkg::ele_apb_req_t apb_req, // bus in
  input wire ele_pkg::ele_apb_rsp_t apb_rsp, // bus out
  input wire logic [ele_pkg::ELE_PINS-1:0] gpio_in, // pins
  input wire logic supply_threshold_monitor, // monitor
  input wire logic stop_mode, // stop
  input wire logic irq, // interrupt
  input wire logic [ele_pkg::ELE_LINES-1:0] event_pulse, // events
  input wire logic wake_req // wake
);
  logic acc;
  logic rd;
  assign acc = apb_req.psel & apb_req.penable;
  assign rd = acc & ~apb_req.pwrite;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_rdy; apb_rsp.pready; endproperty
  a_rdy: assert property (p_rdy)
    else $error("pready low");
  property p_err; apb_rsp.pslverr |-> acc; endproperty
  a_err: assert property (p_err)
    else $error("pslverr outside access");
  property p_unm; acc && apb_req.paddr > ELE_OFF_STAT |-> apb_rsp.pslverr; endproperty
  a_unm: assert property (p_unm)
    else $error("no error on unmapped");
  property p_clr; rd && apb_req.paddr == ELE_OFF_CLR |-> apb_rsp.prdata == '0; endproperty
  a_clr: assert property (p_clr)
    else $error("clear register reads nonzero");
  property p_stat; rd && apb_req.paddr == ELE_OFF_STAT |-> apb_rsp.prdata[0] == $past(stop_mode);
  endproperty
  a_stat: assert property (p_stat)
    else $error("status stop bit wrong");
  property p_wk; stop_mode && irq |-> wake_req; endproperty
  a_wk: assert property (p_wk)
    else $error("no wake with interrupt in stop");
  property p_run; wake_req |-> stop_mode; endproperty
  a_run: assert property (p_run)
    else $error("wake outside stop");
  property p_one; (event_pulse & $past(event_pulse)) == '0; endproperty
  a_one: assert property (p_one)
    else $error("event pulse longer than a cycle");
  property p_fall; $fell(irq) |-> $past(acc && apb_req.pwrite) || $past(acc && apb_req.pwrite, 2);
  endproperty
  a_fall: assert property (p_fall)
    else $error("irq dropped without a write");
  property p_rst; $rose(reset_n) |-> !irq && event_pulse == '0; endproperty
  a_rst: assert property (p_rst)
    else $error("outputs active after reset");
  c_irq: cover property ($rose(irq));
  c_wake: cover property (wake_req);
  c_evt: cover property (event_pulse != '0);
endmodule : ele_chk

/* File: ele_pins_model.sv */
// Far-side model: pin levels and supply monitor output.
// Assumes the bench calls its tasks through the instance.
`timescale 1ns/1ps
module ele_pins_model (
  input wire logic core_clk, // bus clock
  output logic [18:0] lines // pins 0..17, monitor at 18
);
  initial lines = '0;
  task automatic drive(input int i, input logic v);
    @(posedge core_clk);
    lines[i] <= v;
  endtask : drive
  // Shorter than a clock and between rising edges, so no posedge sampler could see it
  task automatic pulse(input int i);
    @(posedge core_clk);
    #7 lines[i] = 1'b1;
    #5 lines[i] = 1'b0;
  endtask : pulse
endmodule : ele_pins_model

/* File: ele_top_test.sv */
// Bench for the pin event unit: APB master, pin model, scenarios.
// Assumes edge latency of at most 4 clocks and pready from the unit.
`timescale 1ns/1ps
module ele_top_test;
  import ele_pkg::*;
  logic core_clk, reset_n, stop_mode, irq, wake_req, re;
  ele_apb_req_t apb_req;
  ele_apb_rsp_t apb_rsp;
  logic [18:0] lines;
  logic [ELE_LINES-1:0] event_pulse;
  logic [31:0] rv;
  int miscompares, check_count, evt_n;
  ele_pins_model pins (.core_clk(core_clk), .lines(lines));
  ele_top dut (.core_clk(core_clk), .reset_n(reset_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .gpio_in(lines[17:0]), .supply_threshold_monitor(lines[18]),
    .stop_mode(stop_mode), .irq(irq), .event_pulse(event_pulse), .wake_req(wake_req));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (event_pulse[0] === 1'b1) evt_n++;
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Request stands until the edge that samples pready high; the answer is
  // taken at that edge, then released; only the watchdog ends a stuck wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (apb_rsp.pready !== 1'b1);
    rv = apb_rsp.prdata;
    re = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(negedge core_clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rv);
  endtask : rdchk
  task w5;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
  endtask : w5
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset;
    rdchk(ELE_OFF_SRC1, 32'h0, "src1");
    rdchk(ELE_OFF_RISE, 32'h0, "rise");
    rdchk(ELE_OFF_PEND, 32'h0, "pend");
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped err", 32'h1, 32'(re));
    chk("irq", 32'h0, 32'(irq));
  endtask : t_reset
  task t_route;
    wr(ELE_OFF_SRC1, 32'h1100);
    wr(ELE_OFF_RISE, 32'h20);
    wr(ELE_OFF_INTEN, 32'h20);
    pins.drive(17, 1'b1);
    w5();
    rdchk(ELE_OFF_PEND, 32'h20, "pend pin17");
    chk("irq", 32'h1, 32'(irq));
    pins.drive(17, 1'b0);
    w5();
    rdchk(ELE_OFF_PEND, 32'h20, "pend held");
    wr(ELE_OFF_PEND, 32'h20);
    rdchk(ELE_OFF_PEND, 32'h0, "pend cleared");
    chk("irq", 32'h0, 32'(irq));
    pins.drive(17, 1'b1);
    w5();
    rdchk(ELE_OFF_PEND, 32'h20, "pend again");
    wr(ELE_OFF_CLR, 32'h20);
    rdchk(ELE_OFF_CLR, 32'h0, "clr");
    rdchk(ELE_OFF_PEND, 32'h0, "pend");
    pins.drive(17, 1'b0);
    w5();
  endtask : t_route
  task t_modes;
    wr(ELE_OFF_EVTEN, 32'h1);
    for (int m = 1; m < 4; m++) begin
      wr(ELE_OFF_RISE, 32'(m & 1));
      wr(ELE_OFF_FALL, 32'(m >> 1));
      evt_n = 0;
      pins.drive(0, 1'b1);
      w5();
      pins.drive(0, 1'b0);
      w5();
      chk("events", (m == 3) ? 32'h2 : 32'h1, 32'(evt_n));
      rdchk(ELE_OFF_PEND, 32'h1, "pend");
      chk("masked irq", 32'h0, 32'(irq));
      wr(ELE_OFF_PEND, 32'h1);
    end
  endtask : t_modes
  task t_narrow;
    wr(ELE_OFF_SRC0, 32'h0300);
    wr(ELE_OFF_RISE, 32'h2);
    wr(ELE_OFF_FALL, 32'h0);
    wr(ELE_OFF_INTEN, 32'h2);
    pins.pulse(3);
    w5();
    rdchk(ELE_OFF_PEND, 32'h2, "pend narrow");
    chk("irq", 32'h1, 32'(irq));
    wr(ELE_OFF_CLR, 32'h2);
    chk("irq", 32'h0, 32'(irq));
  endtask : t_narrow
  task t_stop;
    @(posedge core_clk);
    stop_mode <= 1'b1;
    wr(ELE_OFF_RISE, 32'h10000);
    wr(ELE_OFF_INTEN, 32'h10000);
    pins.drive(18, 1'b1);
    w5();
    chk("wake", 32'h1, 32'(wake_req));
    rdchk(ELE_OFF_STAT, 32'h7, "stat");
    rdchk(ELE_OFF_PEND, 32'h10000, "pend monitor");
    wr(ELE_OFF_CLR, 32'h10000);
    chk("wake", 32'h0, 32'(wake_req));
  endtask : t_stop
  initial begin
    reset_n = 1'b0;
    stop_mode = 1'b0;
    apb_req = '0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_route();
    t_modes();
    t_narrow();
    t_stop();
    report_and_stop();
  end
  // Whole run is under a thousand clocks; this span leaves wide margin
  initial begin
    #100us;
    miscompares++;
    report_and_stop();
  end
endmodule : ele_top_test
bind ele_top ele_chk u_chk (.core_clk(core_clk), .reset_n(reset_n), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .gpio_in(gpio_in), .supply_threshold_monitor(supply_threshold_monitor),
  .stop_mode(stop_mode), .irq(irq), .event_pulse(event_pulse), .wake_req(wake_req));
